// >>> logic/fwp_defs.vh
// Constants for the flash write-protect and mapping control block.
// Included by the controller, the checker and the bench; definitions only.
`ifndef FWP_DEFS_VH
`define FWP_DEFS_VH

// Register indices (printed offsets are these times four, so all multiples of four)
`define FWP_IDX_STAGED      12'h fd0
`define FWP_IDX_COMMIT      12'h fd1
`define FWP_IDX_MONITOR     12'h fd2
`define FWP_IDX_STATUS      12'h fd3

// Field positions in the staged control register
`define FWP_WP_HI           7
`define FWP_WP_LO           5
`define FWP_ROM_BIT         4
`define FWP_AREA_HI         3
`define FWP_AREA_LO         2

// Reset and encodings
`define FWP_STAGED_RST      8'h40
`define FWP_WP_BLOCK        3'h2
`define FWP_WP_ALLOW        3'h5
`define FWP_AREA_STD        2'h0
`define FWP_AREA_SWAP       2'h2
`define FWP_COMMIT_KEY      8'hd5

`endif

// >>> logic/fwp_sync2.v
// Two-flop synchroniser for one level input.
// Assumes the input is asynchronous to clk.
`default_nettype none

module fwp_sync2
(
  input  wire clk,
  input  wire rst_n,
  input  wire din,
  output wire dout
);

  reg meta_ff;
  reg sync_ff;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

`default_nettype wire

// >>> logic/fwp_ctrl.v
// Flash write-protect, boot ROM visibility and area mapping control.
// Assumes an APB master on pclk and a serial programming mode strap pin.
`default_nettype none
`include "fwp_defs.vh"

module fwp_ctrl
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [13:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        serial_mode_pin,
  input  wire        flash_cmd_req,
  output reg         flash_cmd_go,
  output reg         flash_active,
  output reg         code_upper_to_data,
  output reg         loader_rom_visible,
  output reg         flash_cmd_enabled
);

  reg  [7:0]  staged_ff;
  reg  [7:0]  active_ff;
  reg  [31:0] prdata_ff;
  reg         slverr_ff;
  reg         ready_ff;
  reg         blocked_cnt_seen_ff;
  reg  [7:0]  nxt_staged;
  reg  [7:0]  nxt_active;
  reg  [31:0] nxt_prdata;
  reg         nxt_slverr;
  wire        serial_mode;
  wire        access;
  wire        wr;
  wire [11:0] idx;
  wire        hit_staged;
  wire        hit_commit;
  wire        hit_monitor;
  wire        hit_status;
  wire [2:0]  act_wp;
  wire        act_allow;
  wire        act_rom;
  wire [1:0]  act_area;
  wire [7:0]  monitor_val;
  wire        setup;
  wire        key_ok;
  wire        commit_now;
  wire [31:0] status_val;
  reg         nxt_blocked;

  fwp_sync2 u_sync
  (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (serial_mode_pin),
    .dout  (serial_mode)
  );

  // One wait-free access phase; ready is a flop held high
  assign access  = psel & penable;
  assign wr      = access & pwrite;
  assign idx     = paddr[13:2];
  assign hit_staged  = (idx == `FWP_IDX_STAGED);
  assign hit_commit  = (idx == `FWP_IDX_COMMIT);
  assign hit_monitor = (idx == `FWP_IDX_MONITOR);
  assign hit_status  = (idx == `FWP_IDX_STATUS);
  assign pready  = ready_ff;
  assign pslverr = slverr_ff;
  assign setup      = psel & ~penable;
  assign key_ok     = (pwdata[7:0] == `FWP_COMMIT_KEY);
  assign commit_now = wr & hit_commit & key_ok;

  assign act_wp    = active_ff[`FWP_WP_HI:`FWP_WP_LO];
  assign act_allow = (act_wp == `FWP_WP_ALLOW);
  assign act_rom   = active_ff[`FWP_ROM_BIT];
  assign act_area  = active_ff[`FWP_AREA_HI:`FWP_AREA_LO];

  // Monitor layout: allow flag, rom bit ORed with serial mode, area field
  assign monitor_val = {2'h0, act_allow, serial_mode | act_rom, act_area, 2'h0};
  assign status_val  = {29'h0000_0000, blocked_cnt_seen_ff, serial_mode, act_allow};

  // Setup phase decode: read data and error flag chosen here,
  // so both already stand through the access phase
  always @*
  begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    if (setup)
    begin
      if (hit_staged)
      begin
        nxt_prdata = {24'h00_0000, staged_ff};
      end
      else if (hit_commit)
      begin
        nxt_prdata = 32'h0000_0000;
      end
      else if (hit_monitor)
      begin
        nxt_prdata = {24'h00_0000, monitor_val};
        nxt_slverr = pwrite;
      end
      else if (hit_status)
      begin
        nxt_prdata = status_val;
        nxt_slverr = pwrite;
      end
      else
      begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = 1'b1;
      end
    end
  end

  // Access phase decode: staged writes and key commits
  always @*
  begin
    nxt_staged = staged_ff;
    nxt_active = active_ff;
    if (wr)
    begin
      if (hit_staged)
      begin
        nxt_staged = {pwdata[7:2], 2'h0};
      end
      else if (hit_commit)
      begin
        if (key_ok)
        begin
          nxt_active = staged_ff;
        end
      end
    end
  end

  // Blocked-request flag; a request in the commit cycle
  // wins over the clear, so no blocked request is lost
  always @*
  begin
    nxt_blocked = blocked_cnt_seen_ff;
    if (flash_cmd_req & ~act_allow)
    begin
      nxt_blocked = 1'b1;
    end
    else if (commit_now)
    begin
      nxt_blocked = 1'b0;
    end
  end

  // Staged copy, written freely by software
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      staged_ff <= `FWP_STAGED_RST;
    end
    else
    begin
      staged_ff <= nxt_staged;
    end
  end

  // Active copy, moved only by a key commit
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_ff <= `FWP_STAGED_RST;
    end
    else
    begin
      active_ff <= nxt_active;
    end
  end

  // Bus response; ready rises on the first edge after reset
  // and stays, so every access completes without waits
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
      ready_ff  <= 1'b0;
    end
    else
    begin
      ready_ff  <= 1'b1;
      slverr_ff <= nxt_slverr;
      if (setup)
      begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  always @*
  begin
    prdata = prdata_ff;
  end

  // Command gate: a request passes only under the allow code
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flash_cmd_go <= 1'b0;
    end
    else
    begin
      flash_cmd_go <= flash_cmd_req & act_allow;
    end
  end

  // Command enable as seen by the flash sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flash_cmd_enabled <= 1'b0;
    end
    else
    begin
      flash_cmd_enabled <= act_allow;
    end
  end

  // Array wake-up once the allow code is in force
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flash_active <= 1'b0;
    end
    else
    begin
      flash_active <= act_allow;
    end
  end

  // Code upper half seen in data space
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_upper_to_data <= 1'b0;
    end
    else
    begin
      code_upper_to_data <= (act_area == `FWP_AREA_SWAP);
    end
  end

  // Loader ROM always shown in serial mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loader_rom_visible <= 1'b0;
    end
    else
    begin
      loader_rom_visible <= serial_mode | act_rom;
    end
  end

  // Sticky blocked-request flag
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blocked_cnt_seen_ff <= 1'b0;
    end
    else
    begin
      blocked_cnt_seen_ff <= nxt_blocked;
    end
  end

endmodule

`default_nettype wire

// >>> tb/fwp_checker.sv
// Port-level assertions for the flash protect and mapping control.
// Assumes binding to fwp_ctrl; one clock, pclk.
`default_nettype none
`include "fwp_defs.vh"
module fwp_checker
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_mode_pin,
  input wire logic        flash_cmd_req,
  input wire logic        flash_cmd_go,
  input wire logic        flash_active,
  input wire logic        code_upper_to_data,
  input wire logic        loader_rom_visible,
  input wire logic        flash_cmd_enabled
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire key = acc && pwrite && paddr == {`FWP_IDX_COMMIT, 2'h0} && pwdata[7:0] == 8'hd5;
  // No key this cycle, then one settling edge
  sequence s_quiet;
    !key ##1 1;
  endsequence
  chk_cmd_gate: assert property (flash_cmd_go |-> flash_active && $past(flash_cmd_req))
    else $error("Command passed while blocked");
  chk_en_mirror: assert property (flash_cmd_enabled == flash_active)
    else $error("Enable differs from active");
  chk_no_wait: assert property (acc |-> pready)
    else $error("Unexpected wait state");
  chk_wp_commit: assert property (s_quiet |=> $stable(flash_active))
    else $error("Protect changed without key");
  chk_area_commit: assert property (s_quiet |=> $stable(code_upper_to_data))
    else $error("Mapping changed without key");
  chk_serial_rom: assert property (serial_mode_pin [*4] |=> loader_rom_visible)
    else $error("Loader ROM hidden in serial mode");
  chk_mon_ro: assert property (acc && pwrite && paddr == {`FWP_IDX_MONITOR, 2'h0} |-> pslverr)
    else $error("Monitor write not refused");
  chk_unmapped_addr: assert property (acc && paddr == 14'h0 |-> pslverr && prdata == 32'h0)
    else $error("Unmapped access not refused");
endmodule
bind fwp_ctrl fwp_checker fwp_checker_inst (.*);
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the flash protect and mapping control.
// Assumes the checker is bound in; pclk at 50 MHz.
`default_nettype none
`include "fwp_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic serial_mode_pin = 0, flash_cmd_req = 0;
  logic req_hold = 0, look = 0, old_al = 0;
  logic [3:0] out_q[$];
  logic [13:0] paddr = 0;
  logic [31:0] pwdata = 0, rs = 32'h03e769eb, exp_q[$];
  wire logic [31:0] prdata;
  wire pready, pslverr, flash_cmd_go, flash_active, code_upper_to_data;
  wire loader_rom_visible, flash_cmd_enabled;
  wire logic [3:0] outs = {flash_active, flash_cmd_enabled, code_upper_to_data, loader_rom_visible};
  int bad_count = 0, n_checks = 0, cyc = 0;
  localparam logic [13:0] st_a = {`FWP_IDX_STAGED, 2'h0};
  localparam logic [13:0] ck_a = {`FWP_IDX_COMMIT, 2'h0};
  localparam logic [13:0] mn_a = {`FWP_IDX_MONITOR, 2'h0};
  localparam logic [13:0] sa_a = {`FWP_IDX_STATUS, 2'h0};
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  fwp_ctrl fwp_ctrl_inst (.*);
  always #10 pclk = ~pclk;
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t read %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_out(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t outputs %b exp %b", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // Xorshift source, also drives command requests
  always @(posedge pclk)
  begin
    rs <= xs(rs);
    flash_cmd_req <= rs[0] | req_hold;
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      conclude();
    end
  end
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      cmp(prdata, exp_q.pop_front());
  always @(posedge pclk)
    if (look && out_q.size() > 0)
      cmp_out(outs, out_q.pop_front());
  initial
  begin
    logic [7:0] v;
    logic al;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    xfer(0, st_a, 32'h40);
    xfer(0, mn_a, 32'h0);
    xfer(1, st_a, 32'ha8);
    xfer(0, mn_a, 32'h0);
    xfer(1, ck_a, 32'h12);
    xfer(0, mn_a, 32'h0);
    xfer(0, ck_a, 32'h0);
    xfer(1, mn_a, 32'h0);
    xfer(0, 14'h0, 32'h0);
    repeat (8)
    begin
      v = {rs[1] ? 3'h5 : 3'h2, rs[2], rs[3], 3'h0};
      al = v[7:5] == 3'h5;
      serial_mode_pin <= rs[4];
      req_hold <= 1;
      xfer(1, st_a, {24'h0, v});
      xfer(0, st_a, {24'h0, v});
      xfer(1, ck_a, 32'hd5);
      xfer(0, mn_a, {26'h0, al, v[4] | serial_mode_pin, v[3:2], 2'h0});
      xfer(0, sa_a, {29'h0, !(old_al && al), serial_mode_pin, al});
      old_al = al;
      req_hold <= 0;
      repeat (4) @(posedge pclk);
      out_q.push_back({al, al, v[3:2] == 2'h2, v[4] | serial_mode_pin});
      look <= 1;
      @(posedge pclk);
      look <= 0;
    end
    conclude();
  end
endmodule
`default_nettype wire
